// ===== verilog/bscr_pkg.sv
`default_nettype none
package bscr_pkg;
    // ********************************************************
    // register port shape
    // ********************************************************
    localparam int BSCR_AW = 8;
    localparam int BSCR_DW = 8;
    localparam int BSCR_SRAM_DEPTH = 256;
    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [7:0] BSCR_OFF_CSR = 8'h03;
    localparam logic [7:0] BSCR_OFF_SCRATCH = 8'h06;
    localparam logic [7:0] BSCR_OFF_PRESET = 8'h07;
    localparam logic [7:0] BSCR_OFF_BCFG = 8'h08;
    localparam logic [7:0] BSCR_OFF_SINDEX = 8'h09;
    localparam logic [7:0] BSCR_OFF_SWIN = 8'h0a;
    localparam logic [7:0] BSCR_OFF_LED = 8'h0b;
    localparam logic [7:0] BSCR_OFF_SCTL = 8'h10;
    localparam logic [7:0] BSCR_OFF_SSTAT = 8'h11;
    // ********************************************************
    // field positions, vector index (bit 0 of a field is the lsb)
    // ********************************************************
    localparam int BSCR_CSR_LED = 1;
    localparam int BSCR_BCFG_PRIV = 5;
    localparam int BSCR_BCFG_WP = 3;
    localparam int BSCR_BCFG_WIDE = 0;
    localparam int BSCR_SCTL_WATCHDOG_ENABLE = 3;
    localparam int BSCR_SCTL_FORCE_POWER_DOWN = 1;
    localparam int BSCR_SCTL_GO = 0;
    localparam int BSCR_SSTAT_BUSY = 0;
    localparam int BSCR_PRESET_W = 3;
    // ********************************************************
    // writable-bit masks and reset values
    // ********************************************************
    localparam logic [7:0] BSCR_CSR_MASK = 8'h02;
    localparam logic [7:0] BSCR_BCFG_MASK = 8'h29;
    localparam logic [7:0] BSCR_SCTL_MASK = 8'h0b;
    localparam logic [7:0] BSCR_RST_ZERO = 8'h00;
    localparam logic [7:0] BSCR_RST_BCFG = 8'h00;
    localparam logic [3:0] BSCR_PINS_HIGH = 4'hf;
    // ********************************************************
    // watchdog span in clock cycles
    // ********************************************************
    localparam logic [31:0] BSCR_WDOG_CYCLES = 32'h2000_0000;
    // ********************************************************
    // sequencer launch states
    // ********************************************************
    typedef enum logic [1:0] {
        BSCR_SEQ_ARMED = 2'b00,
        BSCR_SEQ_RUN = 2'b01,
        BSCR_SEQ_SPENT = 2'b10
    } bscr_seq_t;
endpackage
`default_nettype wire

// ===== verilog/bscr_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module bscr_wdog #(
    parameter logic [31:0] LIMIT = bscr_pkg::BSCR_WDOG_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control
    input wire logic wdog_enable,
    // expiry pulse
    output logic wdog_fire
);
    import bscr_pkg::*;

    logic [31:0] count_reg;
    logic fire_reg;

    // ********************************************************
    // cycle counter
    // ********************************************************
    // a cleared enable zeroes the count at once, so no stale time
    // carries over into the next enabled period
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wdog_enable || fire_reg) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    // expiry pulse one cycle wide after the last counted cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= wdog_enable && !fire_reg && (count_reg == LIMIT - 32'h0000_0001);
        end
    end

    assign wdog_fire = fire_reg;

    // ********************************************************
    // checks
    // ********************************************************
    wdog_off_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wdog_enable |=> !wdog_fire)
        else $error("watchdog fired while disabled");
    wdog_span_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wdog_fire |-> $past(count_reg) == LIMIT - 32'h0000_0001)
        else $error("watchdog fired at wrong count");
endmodule
`default_nettype wire

// ===== verilog/bscr_top.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bscr_top #(
    parameter logic [31:0] WDOG_CYCLES = bscr_pkg::BSCR_WDOG_CYCLES
) (
    // clock and resets
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic light_rst,
    // register port
    input wire logic [bscr_pkg::BSCR_AW-1:0] reg_addr,
    input wire logic [bscr_pkg::BSCR_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bscr_pkg::BSCR_DW-1:0] reg_rdata,
    // board status inputs
    input wire logic [bscr_pkg::BSCR_PRESET_W-1:0] clock_preset_code,
    input wire logic [7:0] led_activity,
    input wire logic power_request,
    input wire logic seq_done,
    // shared pin sources
    input wire logic [3:0] spi_cs_n_in,
    input wire logic [3:0] sd_data_hi_in,
    // board controls
    output logic private_bus_access,
    output logic emulator_write_protect_n,
    output logic card_wide_mode_select,
    output logic [3:0] shared_pin_out,
    output logic [3:0] spi_cs_n_out,
    output logic [3:0] sd_data_hi_out,
    output logic [7:0] led_drive,
    output logic system_power_on,
    output logic force_power_down,
    output logic seq_start,
    output logic seq_busy,
    output logic system_reset_req
);
    import bscr_pkg::*;

    logic [7:0] scratch_reg;
    logic [7:0] csr_reg;
    logic [7:0] bcfg_reg;
    logic [7:0] sindex_reg;
    logic [7:0] led_reg;
    logic [7:0] sctl_reg;
    logic [7:0] sctl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] led_drive_reg;
    logic [7:0] sram_mem [BSCR_SRAM_DEPTH];
    logic [7:0] sram_byte;
    logic wdog_fire;
    logic soft_rst;
    logic busy_reg;
    logic start_reg;
    bscr_seq_t seq_state_reg;
    bscr_seq_t seq_state_next;

    // ********************************************************
    // decode
    // ********************************************************
    // light resets come from the debug port or our own watchdog
    assign soft_rst = light_rst || wdog_fire;
    assign sram_byte = sram_mem[sindex_reg];

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = reg_wr && (reg_addr == off);
    endfunction

    // ********************************************************
    // registers kept through light resets
    // ********************************************************
    // scratch only answers to the full power/chassis reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scratch_reg <= BSCR_RST_ZERO;
        end else if (wr_hit(BSCR_OFF_SCRATCH)) begin
            scratch_reg <= reg_wdata;
        end
    end

    // sram index survives light resets
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sindex_reg <= BSCR_RST_ZERO;
        end else if (wr_hit(BSCR_OFF_SINDEX)) begin
            sindex_reg <= reg_wdata;
        end
    end

    // the window is the indexed array byte itself, so the array is cleared by
    // the full reset only; light resets leave software's bytes in place
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < BSCR_SRAM_DEPTH; i++) begin
                sram_mem[i] <= BSCR_RST_ZERO;
            end
        end else if (wr_hit(BSCR_OFF_SWIN)) begin
            sram_mem[sindex_reg] <= reg_wdata;
        end
    end

    // ********************************************************
    // registers cleared by any reset
    // ********************************************************
    // reserved bits are masked off on write so they stay zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            csr_reg <= BSCR_RST_ZERO;
        end else if (wr_hit(BSCR_OFF_CSR)) begin
            csr_reg <= reg_wdata & BSCR_CSR_MASK;
        end
    end

    // board config acts the cycle after the write, no resequence
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            bcfg_reg <= BSCR_RST_BCFG;
        end else if (wr_hit(BSCR_OFF_BCFG)) begin
            bcfg_reg <= reg_wdata & BSCR_BCFG_MASK;
        end
    end

    // led pattern
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            led_reg <= BSCR_RST_ZERO;
        end else if (wr_hit(BSCR_OFF_LED)) begin
            led_reg <= reg_wdata;
        end
    end

    // ********************************************************
    // sequencer control
    // ********************************************************
    // power-off bit may be set by software but only a reset clears it
    always_comb begin
        sctl_next = sctl_reg;
        if (wr_hit(BSCR_OFF_SCTL)) begin
            sctl_next = reg_wdata & BSCR_SCTL_MASK;
            sctl_next[BSCR_SCTL_FORCE_POWER_DOWN] = reg_wdata[BSCR_SCTL_FORCE_POWER_DOWN]
                | sctl_reg[BSCR_SCTL_FORCE_POWER_DOWN];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            sctl_reg <= BSCR_RST_ZERO;
        end else begin
            sctl_reg <= sctl_next;
        end
    end

    // launch once per go; go must drop to zero to rearm
    always_comb begin
        seq_state_next = seq_state_reg;
        case (seq_state_reg)
            BSCR_SEQ_ARMED: begin
                if (sctl_reg[BSCR_SCTL_GO]) begin
                    seq_state_next = BSCR_SEQ_RUN;
                end
            end
            BSCR_SEQ_RUN: begin
                if (seq_done) begin
                    seq_state_next = BSCR_SEQ_SPENT;
                end
            end
            BSCR_SEQ_SPENT: begin
                if (!sctl_reg[BSCR_SCTL_GO]) begin
                    seq_state_next = BSCR_SEQ_ARMED;
                end
            end
            default: begin
                seq_state_next = BSCR_SEQ_ARMED;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            seq_state_reg <= BSCR_SEQ_ARMED;
        end else begin
            seq_state_reg <= seq_state_next;
        end
    end

    // start pulse on entry to run, busy held until done
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            start_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            start_reg <= (seq_state_reg == BSCR_SEQ_ARMED) && sctl_reg[BSCR_SCTL_GO];
            busy_reg <= (seq_state_next == BSCR_SEQ_RUN);
        end
    end

    // ********************************************************
    // watchdog
    // ********************************************************
    bscr_wdog #(
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wdog_enable(sctl_reg[BSCR_SCTL_WATCHDOG_ENABLE]),
        .wdog_fire(wdog_fire)
    );

    // ********************************************************
    // read port
    // ********************************************************
    // data stands one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = BSCR_RST_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                BSCR_OFF_CSR: rdata_next = csr_reg;
                BSCR_OFF_SCRATCH: rdata_next = scratch_reg;
                BSCR_OFF_PRESET: rdata_next = {5'h00, clock_preset_code};
                BSCR_OFF_BCFG: rdata_next = bcfg_reg;
                BSCR_OFF_SINDEX: rdata_next = sindex_reg;
                BSCR_OFF_SWIN: rdata_next = sram_byte;
                BSCR_OFF_LED: rdata_next = led_reg;
                BSCR_OFF_SCTL: rdata_next = sctl_reg;
                BSCR_OFF_SSTAT: rdata_next = {7'h00, busy_reg};
                default: rdata_next = BSCR_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= BSCR_RST_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ********************************************************
    // board outputs
    // ********************************************************
    // leds registered so they never glitch when the override flips
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            led_drive_reg <= BSCR_RST_ZERO;
        end else if (csr_reg[BSCR_CSR_LED]) begin
            led_drive_reg <= led_reg;
        end else begin
            led_drive_reg <= led_activity;
        end
    end

    assign reg_rdata = rdata_reg;
    assign led_drive = led_drive_reg;
    assign private_bus_access = bcfg_reg[BSCR_BCFG_PRIV];
    assign emulator_write_protect_n = bcfg_reg[BSCR_BCFG_WP];
    assign card_wide_mode_select = bcfg_reg[BSCR_BCFG_WIDE];
    // one pin set shared: wide card data when clear, spi when set
    assign shared_pin_out = card_wide_mode_select ? spi_cs_n_in : sd_data_hi_in;
    assign spi_cs_n_out = card_wide_mode_select ? spi_cs_n_in : BSCR_PINS_HIGH;
    assign sd_data_hi_out = card_wide_mode_select ? BSCR_PINS_HIGH : sd_data_hi_in;
    assign force_power_down = sctl_reg[BSCR_SCTL_FORCE_POWER_DOWN];
    assign system_power_on = power_request && !force_power_down;
    assign seq_start = start_reg;
    assign seq_busy = busy_reg;
    assign system_reset_req = wdog_fire;

    // ********************************************************
    // checks
    // ********************************************************
    scratch_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        light_rst && !reg_wr |=> scratch_reg == $past(scratch_reg))
        else $error("scratch lost on light reset");
    preset_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == BSCR_OFF_PRESET
        |=> reg_rdata == {5'h00, $past(clock_preset_code)})
        else $error("preset code misread");
    priv_live_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_hit(BSCR_OFF_BCFG) && !soft_rst
        |=> private_bus_access == $past(reg_wdata[BSCR_BCFG_PRIV]))
        else $error("private access not applied");
    wp_live_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_hit(BSCR_OFF_BCFG) && !soft_rst
        |=> emulator_write_protect_n == $past(reg_wdata[BSCR_BCFG_WP]))
        else $error("write protect not applied");
    pin_share_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !card_wide_mode_select |-> spi_cs_n_out == BSCR_PINS_HIGH
        && shared_pin_out == sd_data_hi_in)
        else $error("pin sharing wrong");
    sram_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == BSCR_OFF_SWIN |=> reg_rdata == $past(sram_byte))
        else $error("window read wrong");
    sram_roundtrip_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_hit(BSCR_OFF_SWIN) ##1 !reg_wr ##1 (reg_rd && reg_addr == BSCR_OFF_SWIN)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("window write not stored");
    led_override_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        csr_reg[BSCR_CSR_LED] |=> led_drive == $past(led_reg))
        else $error("led override ignored");
    force_power_down_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        force_power_down && !soft_rst |=> force_power_down)
        else $error("power restored by software");
    go_rearm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_start |=> !seq_start [*2])
        else $error("sequencer relaunched");
    busy_report_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == BSCR_OFF_SSTAT
        |=> reg_rdata == {7'h00, $past(busy_reg)})
        else $error("busy status misread");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == BSCR_OFF_SCTL |=> reg_rdata[7:4] == 4'h0
        && !reg_rdata[2])
        else $error("reserved bits read nonzero");
    cov_seq_run_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        seq_start ##[1:20] !seq_busy);
    cov_force_power_down_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(force_power_down));
    cov_light_keep_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        light_rst && scratch_reg != BSCR_RST_ZERO);
endmodule
`default_nettype wire

// ===== bench/bscr_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// sequencer stand-in
// ****************************************
module bscr_seq_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // launch in, done out
    input wire logic seq_start,
    input wire logic [3:0] done_delay,
    output logic seq_done
);
    logic [3:0] cnt_reg;
    logic run_reg;
    // delay is an input so the bench can answer promptly or slowly
    always_ff @(posedge ref_clk) begin
        seq_done <= 1'b0;
        if (sys_rst) begin
            run_reg <= 1'b0;
            cnt_reg <= 4'h0;
        end else if (seq_start) begin
            run_reg <= 1'b1;
            cnt_reg <= done_delay;
        end else if (run_reg) begin
            if (cnt_reg == 4'h0) begin
                run_reg <= 1'b0;
                seq_done <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/board_system_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module board_system_control_regs_test;
    import bscr_pkg::*;
    logic ref_clk, sys_rst, light_rst, reg_wr, reg_rd, power_request, seq_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, led_activity, led_drive, n;
    logic [2:0] clock_preset_code;
    logic [3:0] spi_cs_n_in, sd_data_hi_in, shared_pin_out, spi_cs_n_out;
    logic [3:0] sd_data_hi_out, done_delay;
    logic private_bus_access, emulator_write_protect_n, card_wide_mode_select;
    logic system_power_on, force_power_down, seq_start, seq_busy, system_reset_req;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // watchdog span cut to 16 cycles to keep the run short
    bscr_top #(.WDOG_CYCLES(32'h10)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .light_rst(light_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clock_preset_code(clock_preset_code), .led_activity(led_activity),
        .power_request(power_request), .seq_done(seq_done), .spi_cs_n_in(spi_cs_n_in),
        .sd_data_hi_in(sd_data_hi_in), .private_bus_access(private_bus_access),
        .emulator_write_protect_n(emulator_write_protect_n),
        .card_wide_mode_select(card_wide_mode_select), .shared_pin_out(shared_pin_out),
        .spi_cs_n_out(spi_cs_n_out), .sd_data_hi_out(sd_data_hi_out), .led_drive(led_drive),
        .system_power_on(system_power_on), .force_power_down(force_power_down),
        .seq_start(seq_start), .seq_busy(seq_busy), .system_reset_req(system_reset_req)
    );
    bscr_seq_model seq_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .seq_start(seq_start),
        .done_delay(done_delay), .seq_done(seq_done)
    );
    // ****************************************
    // clock, timeout and closing
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // the whole run needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40 && seq_busy === 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        #1 chk("wp_n", emulator_write_protect_n, 8'h0);
        chk("cs_out", spi_cs_n_out, 8'hf);
        chk("sd_out", sd_data_hi_out, sd_data_hi_in);
        rdc(BSCR_OFF_SCRATCH, 8'h00, "scratch");
        rdc(BSCR_OFF_SWIN, 8'h00, "window");
        rdc(BSCR_OFF_SCTL, 8'h00, "sctl");
        rdc(8'h40, 8'h00, "unmapped");
        for (int c = 0; c < 8; c++) begin
            clock_preset_code <= c[2:0];
            rdc(BSCR_OFF_PRESET, {5'h0, c[2:0]}, "preset");
        end
    endtask
    task automatic t_sram();
        logic [7:0] idx[3] = '{8'h00, 8'h40, 8'hff};
        foreach (idx[i]) begin
            wr(BSCR_OFF_SINDEX, idx[i]);
            wr(BSCR_OFF_SWIN, idx[i] ^ 8'h5a);
            rdc(BSCR_OFF_SWIN, idx[i] ^ 8'h5a, "window");
        end
        foreach (idx[i]) begin
            wr(BSCR_OFF_SINDEX, idx[i]);
            rdc(BSCR_OFF_SWIN, idx[i] ^ 8'h5a, "window");
        end
        rdc(BSCR_OFF_SINDEX, 8'hff, "index");
    endtask
    task automatic t_bcfg();
        wr(BSCR_OFF_BCFG, 8'hff);
        #1 chk("priv", private_bus_access, 8'h1);
        chk("wp_n", emulator_write_protect_n, 8'h1);
        chk("wide", card_wide_mode_select, 8'h1);
        chk("pins", shared_pin_out, spi_cs_n_in);
        chk("sd_out", sd_data_hi_out, 8'hf);
        chk("cs_out", spi_cs_n_out, spi_cs_n_in);
        rdc(BSCR_OFF_BCFG, 8'h29, "bcfg");
        wr(BSCR_OFF_BCFG, 8'h00);
        #1 chk("priv", private_bus_access, 8'h0);
        chk("wp_n", emulator_write_protect_n, 8'h0);
        chk("pins", shared_pin_out, sd_data_hi_in);
        chk("cs_out", spi_cs_n_out, 8'hf);
    endtask
    task automatic t_led();
        led_activity <= 8'h3c;
        wr(BSCR_OFF_LED, 8'ha5);
        #1 chk("led", led_drive, 8'h3c);
        wr(BSCR_OFF_CSR, 8'hff);
        rdc(BSCR_OFF_CSR, 8'h02, "csr");
        chk("led", led_drive, 8'ha5);
        wr(BSCR_OFF_CSR, 8'h00);
        @(posedge ref_clk);
        #1 chk("led", led_drive, 8'h3c);
    endtask
    task automatic t_power();
        wr(BSCR_OFF_SCRATCH, 8'ha5);
        wr(BSCR_OFF_BCFG, 8'h29);
        wr(BSCR_OFF_SCTL, 8'h02);
        #1 chk("pwr", system_power_on, 8'h0);
        chk("force_power_down", force_power_down, 8'h1);
        wr(BSCR_OFF_SCTL, 8'h00);
        rdc(BSCR_OFF_SCTL, 8'h02, "sctl");
        chk("pwr", system_power_on, 8'h0);
        @(posedge ref_clk);
        light_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        light_rst <= 1'b0;
        #1 chk("pwr", system_power_on, 8'h1);
        power_request <= 1'b0;
        #1 chk("pwr", system_power_on, 8'h0);
        power_request <= 1'b1;
        rdc(BSCR_OFF_SCRATCH, 8'ha5, "scratch");
        rdc(BSCR_OFF_SINDEX, 8'hff, "index");
        rdc(BSCR_OFF_SWIN, 8'ha5, "window");
        rdc(BSCR_OFF_BCFG, 8'h00, "bcfg");
    endtask
    task automatic t_seq();
        done_delay <= 4'd9;
        wr(BSCR_OFF_SCTL, 8'h01);
        @(posedge ref_clk);
        #1 chk("start", seq_start, 8'h1);
        chk("busy", seq_busy, 8'h1);
        rdc(BSCR_OFF_SSTAT, 8'h01, "status");
        wait_idle();
        rdc(BSCR_OFF_SSTAT, 8'h00, "status");
        n = 8'h0;
        repeat (10) begin
            @(posedge ref_clk);
            #1 n = n + {7'h0, seq_start};
        end
        chk("relaunch", n, 8'h0);
        done_delay <= 4'd0;
        wr(BSCR_OFF_SCTL, 8'h00);
        wr(BSCR_OFF_SCTL, 8'h01);
        @(posedge ref_clk);
        #1 chk("start", seq_start, 8'h1);
        wait_idle();
        wr(BSCR_OFF_SCTL, 8'h00);
    endtask
    task automatic t_wdog();
        wr(BSCR_OFF_SCTL, 8'h08);
        n = 8'h0;
        while (n < 8'd40 && system_reset_req !== 1'b1) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("wdog_span", n, 8'd16);
        rdc(BSCR_OFF_SCTL, 8'h00, "sctl");
        wr(BSCR_OFF_SCTL, 8'h08);
        repeat (8) @(posedge ref_clk);
        wr(BSCR_OFF_SCTL, 8'h00);
        n = 8'h0;
        repeat (30) begin
            @(posedge ref_clk);
            #1 n = n + {7'h0, system_reset_req};
        end
        chk("wdog_off", n, 8'h0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        light_rst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        clock_preset_code = 3'h0;
        led_activity = 8'h00;
        power_request = 1'b1;
        spi_cs_n_in = 4'h6;
        sd_data_hi_in = 4'h3;
        done_delay = 4'h0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_sram();
        t_bcfg();
        t_led();
        t_power();
        t_seq();
        t_wdog();
        end_sim();
    end
endmodule
`default_nettype wire
